/* File: rtl/ile_unit.sv */
`timescale 1ns/1ps
module ile_unit
(
	input  wire logic                 sys_clk_in,       // System clock, 125 MHz
	input  wire logic                 rst_in,           // Synchronous reset, active high
	input  wire logic [11:0]          sfr_addr_in,      // Special-function register address
	input  wire logic                 sfr_wr_in,        // Write strobe, one cycle
	input  wire logic                 sfr_rd_in,        // Read strobe, one cycle
	input  wire logic [7:0]           sfr_wdata_in,     // Write data
	output logic      [7:0]           sfr_rdata_out,    // Read data, one cycle after strobe
	input  wire logic [27:3]          src_req_in,       // Source request pulses, same clock
	input  wire logic                 software_irq_in,  // Software interrupt instruction
	input  wire logic                 undef_irq_in,     // Undefined opcode detected
	input  ile_pkg::ile_levels_t      level_in,         // Programmed level per source
	input  wire logic                 ei_in,            // Enable instruction pulse
	input  wire logic                 di_in,            // Disable instruction pulse
	input  wire logic                 return_from_irq_instr_in,          // Return restores master enable
	input  wire logic                 return_from_irq_instr_imf_in,      // Stacked master enable value
	input  wire logic                 cpu_ack_in,       // Core accepts presented request
	output logic                      irq_req_out,      // Request presented to core
	output logic                      irq_nmi_out,      // Presented request is non-maskable
	output logic      [4:0]           irq_src_out,      // Identity of presented source
	output logic      [15:0]          irq_vector_out,   // Vector of presented source
	output logic                      imf_stack_out,    // Master enable captured at acceptance
	output logic                      imf_out           // Current master enable
);

	// Pending latches, one per latched source
	logic [27:3]        pend_q;
	logic [27:3]        pend_d;

	// Source enable flags
	logic [27:4]        en_q;
	logic [27:4]        en_d;

	// Master enable and the copy taken at acceptance
	logic               imf_q;
	logic               imf_d;
	logic               stack_q;
	logic               stack_d;

	// Read data as last captured
	logic [7:0]         rdata_q;
	logic [7:0]         rdata_d;

	// Request shown to the core
	ile_pkg::ile_pres_s pres_q;
	ile_pkg::ile_pres_s pres_d;

	// Core takes the presented request this cycle
	logic               accept;

	// An ack with nothing presented is ignored
	assign accept = cpu_ack_in && pres_q.valid;

	// Latched sources only; software and undefined ids have no latch
	function automatic logic has_latch(
		input logic [4:0] src
	);
		return (int'(src) >= ile_pkg::SRC_WDT) && (int'(src) <= ile_pkg::SRC_HI);
	endfunction : has_latch

	// Write strobe aimed at one register of the map
	function automatic logic wr_at(
		input logic        wr,
		input logic [11:0] addr,
		input logic [11:0] off
	);
		return wr && (addr == off);
	endfunction : wr_at

	// Vector of a latched source
	// Vectors step down two bytes per latch from the watchdog's
	function automatic logic [15:0] vec_of(input int idx);
		logic [15:0] off;
		off = 16'((idx - ile_pkg::SRC_WDT) * 2);
		return ile_pkg::VEC_WDT - off;
	endfunction : vec_of

	// Read view of the four byte registers of either set
	// Unmapped addresses read as zero
	function automatic logic [7:0] rd_view(
		input logic [11:0] addr,
		input logic [27:3] pend,
		input logic [27:4] en,
		input logic        master_enable_flag
	);
		logic [7:0] v;
		v = 8'h00;
		unique case (addr)
			ile_pkg::OFF_EN_LOW:  v = {en[7:4], 3'b000, master_enable_flag};
			ile_pkg::OFF_EN_HIGH: v = en[15:8];
			ile_pkg::OFF_EN_EXT:  v = en[23:16];
			ile_pkg::OFF_EN_TOP:  v = {4'h0, en[27:24]};
			ile_pkg::OFF_PL0:     v = {pend[7:3], 3'b000};
			ile_pkg::OFF_PL1:     v = pend[15:8];
			ile_pkg::OFF_PL2:     v = pend[23:16];
			ile_pkg::OFF_PL3:     v = {4'h0, pend[27:24]};
			default:              v = 8'h00;
		endcase
		return v;
	endfunction : rd_view

	// Latches a software write may clear; zero bits clear, one bits keep
	// Latch 3 is left out, so only acceptance ends a watchdog request
	function automatic logic [27:3] clr_mask(
		input logic [11:0] addr,
		input logic [7:0]  data
	);
		logic [27:3] m;
		m = '0;
		unique case (addr)
			ile_pkg::OFF_PL0: m[7:4]   = ~data[7:4];
			ile_pkg::OFF_PL1: m[15:8]  = ~data;
			ile_pkg::OFF_PL2: m[23:16] = ~data;
			ile_pkg::OFF_PL3: m[27:24] = ~data[3:0];
			default:          m        = '0;
		endcase
		return m;
	endfunction : clr_mask

	// Pending latches: ack clear, software clear, hardware set last so it wins
	// Plain writes only: a read-modify-write would wipe requests seen meanwhile
	always_comb
	begin
		pend_d = pend_q;
		// Acceptance clears only the latch it came from
		if (accept && has_latch(pres_q.src))
		begin
			pend_d[pres_q.src] = 1'b0;
		end
		if (sfr_wr_in)
		begin
			pend_d = pend_d & ~clr_mask(sfr_addr_in, sfr_wdata_in);
		end
		// Only hardware ever sets; a write of 1 is a no-op
		pend_d = pend_d | src_req_in;
	end

	// Source enable flags, plain read/write store
	// Enables take plain whole-field writes of ones and zeros, unlike the clear-only latches
	always_comb
	begin
		en_d = en_q;
		if (sfr_wr_in)
		begin
			unique case (sfr_addr_in)
				ile_pkg::OFF_EN_LOW:  en_d[7:4]   = sfr_wdata_in[7:4];
				ile_pkg::OFF_EN_HIGH: en_d[15:8]  = sfr_wdata_in;
				ile_pkg::OFF_EN_EXT:  en_d[23:16] = sfr_wdata_in;
				ile_pkg::OFF_EN_TOP:  en_d[27:24] = sfr_wdata_in[3:0];
				default:              en_d        = en_q;
			endcase
		end
	end

	// Master enable: acceptance outranks return, instructions and writes
	// Later assignments win, so the order below is the priority order
	always_comb
	begin
		imf_d   = imf_q;
		stack_d = stack_q;
		// Register write is the weakest source
		if (wr_at(sfr_wr_in, sfr_addr_in, ile_pkg::OFF_EN_LOW))
		begin
			imf_d = sfr_wdata_in[ile_pkg::IMF_BIT];
		end
		// Enable instruction
		if (ei_in)
		begin
			imf_d = 1'b1;
		end
		// Disable instruction beats a same-cycle enable
		if (di_in)
		begin
			imf_d = 1'b0;
		end
		// Return restores the value stacked at acceptance
		if (return_from_irq_instr_in)
		begin
			imf_d = return_from_irq_instr_imf_in;
		end
		// Acceptance stacks the old value and masks further requests
		if (accept)
		begin
			stack_d = imf_q;
			imf_d   = 1'b0;
		end
	end

	// Selection from next-state values so a just-accepted latched source is never shown twice
	// Costs a longer path from the strobes to the request flops
	always_comb
	begin
		logic       found;
		logic [1:0] best_lvl;
		found    = 1'b0;
		best_lvl = 2'b00;
		pres_d   = ile_pkg::PRES_RST;
		// Non-maskable first, regardless of enables
		if (pend_d[ile_pkg::SRC_WDT])
		begin
			pres_d = '{valid: 1'b1, nmi: 1'b1, src: ile_pkg::ID_WDT,
			           vector: ile_pkg::VEC_WDT};
		end
		// Latchless requests are levels held by the core
		else if (software_irq_in || undef_irq_in)
		begin
			pres_d.valid  = 1'b1;
			pres_d.nmi    = 1'b1;
			pres_d.src    = software_irq_in ? ile_pkg::ID_SW : ile_pkg::ID_UNDEF;
			pres_d.vector = ile_pkg::VEC_SW;
		end
		// Maskable ones only while the master enable is set
		else if (imf_d)
		begin
			// Scan from lowest basic priority; higher level or equal wins upward
			for (int i = ile_pkg::SRC_HI; i >= ile_pkg::SRC_LO; i--)
			begin
				if (pend_d[i] && en_d[i] &&
				    (!found || (level_in[i] >= best_lvl)))
				begin
					found         = 1'b1;
					best_lvl      = level_in[i];
					pres_d.valid  = 1'b1;
					pres_d.nmi    = 1'b0;
					pres_d.src    = 5'(i);
					pres_d.vector = vec_of(i);
				end
			end
		end
	end

	// Read data held until the next read strobe
	// Reads see the state before any same-cycle write
	always_comb
	begin
		rdata_d = rdata_q;
		if (sfr_rd_in)
		begin
			rdata_d = rd_view(sfr_addr_in, pend_q, en_q, imf_q);
		end
	end

	// Pending latches register
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			pend_q <= ile_pkg::PL_RST;
		end
		else
		begin
			pend_q <= pend_d;
		end
	end

	// Source enable flags register
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			en_q <= ile_pkg::EN_RST;
		end
		else
		begin
			en_q <= en_d;
		end
	end

	// Master enable and stacked copy register
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			imf_q   <= ile_pkg::IMF_RST;
			stack_q <= ile_pkg::IMF_RST;
		end
		else
		begin
			imf_q   <= imf_d;
			stack_q <= stack_d;
		end
	end

	// Read data register
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			rdata_q <= ile_pkg::RDATA_RST;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end

	// Presented request register; nothing shows during reset
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			pres_q <= ile_pkg::PRES_RST;
		end
		else
		begin
			pres_q <= pres_d;
		end
	end

	// Register bus output straight from its flip-flops
	assign sfr_rdata_out  = rdata_q;

	// Presented request, all fields from one register
	assign irq_req_out    = pres_q.valid;
	assign irq_nmi_out    = pres_q.nmi;
	assign irq_src_out    = pres_q.src;
	assign irq_vector_out = pres_q.vector;

	// Master enable and its stacked copy
	assign imf_stack_out  = stack_q;
	assign imf_out        = imf_q;

endmodule : ile_unit

/* File: rtl/ile_pkg.sv */
package ile_pkg;

	// Register bus geometry
	localparam int          ADDR_W      = 12;
	localparam int          DATA_W      = 8;
	localparam int          ID_W        = 5;
	localparam int          VEC_W       = 16;
	localparam int          LVL_W       = 2;

	// Source numbering: latch 3 is the watchdog, 4 to 27 are maskable
	localparam int          SRC_WDT     = 3;
	localparam int          SRC_LO      = 4;
	localparam int          SRC_HI      = 27;

	// Enable register set offsets
	localparam logic [11:0] OFF_EN_LOW  = 12'h03a;
	localparam logic [11:0] OFF_EN_HIGH = 12'h03b;
	localparam logic [11:0] OFF_EN_EXT  = 12'h03c;
	localparam logic [11:0] OFF_EN_TOP  = 12'h03d;

	// Pending latch register offsets
	localparam logic [11:0] OFF_PL0     = 12'hfe0;
	localparam logic [11:0] OFF_PL1     = 12'hfe1;
	localparam logic [11:0] OFF_PL2     = 12'hfe2;
	localparam logic [11:0] OFF_PL3     = 12'hfe3;

	// Field positions
	localparam int          IMF_BIT     = 0;

	// Values after reset
	localparam logic [27:3] PL_RST      = 25'h0000000;
	localparam logic [27:4] EN_RST      = 24'h000000;
	localparam logic        IMF_RST     = 1'b0;
	localparam logic [7:0]  RDATA_RST   = 8'h00;

	// Identity codes for the latchless software and undefined-opcode sources and the watchdog latch
	localparam logic [4:0]  ID_SW       = 5'h01;
	localparam logic [4:0]  ID_UNDEF    = 5'h02;
	localparam logic [4:0]  ID_WDT      = 5'h03;

	// Vector addresses: latch n sits at VEC_WDT - 2*(n-3)
	localparam logic [15:0] VEC_SW      = 16'hfffc;
	localparam logic [15:0] VEC_WDT     = 16'hfff8;

	// Programmed priority level per maskable source
	typedef logic [27:4][1:0] ile_levels_t;

	// Request presented to the core
	typedef struct packed {
		logic        valid;
		logic        nmi;
		logic [4:0]  src;
		logic [15:0] vector;
	} ile_pres_s;

	localparam ile_pres_s PRES_RST = '{valid: 1'b0, nmi: 1'b0, src: 5'h00, vector: 16'h0000};

endpackage : ile_pkg

/* File: verification/ile_unit_props.sv */
`timescale 1ns/1ps
module ile_unit_props
(
	input  wire logic        sys_clk_in,     // Clock
	input  wire logic        rst_in,         // Reset
	input  wire logic [11:0] sfr_addr_in,    // Address
	input  wire logic        sfr_rd_in,      // Read strobe
	input  wire logic [7:0]  sfr_rdata_out,  // Read data
	input  wire logic [27:3] src_req_in,     // Requests
	input  wire logic        cpu_ack_in,     // Accept
	input  wire logic        irq_req_out,    // Presented
	input  wire logic        irq_nmi_out,    // Non-maskable
	input  wire logic [4:0]  irq_src_out,    // Source id
	input  wire logic [15:0] irq_vector_out, // Vector
	input  wire logic        imf_stack_out,  // Stacked enable
	input  wire logic        imf_out         // Master enable
);
	// One domain, so one clock and reset serve every property
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	property p_stk; cpu_ack_in && irq_req_out |=> imf_stack_out == $past(imf_out) && !imf_out; endproperty
	a_stk: assert property (p_stk) else $error("stacked enable wrong");
	property p_msk; irq_req_out && !irq_nmi_out |-> imf_out; endproperty
	a_msk: assert property (p_msk) else $error("maskable shown while disabled");
	property p_wdt; src_req_in[3] |=> irq_req_out && irq_nmi_out && irq_src_out == 5'h03; endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog not presented");
	property p_vec; irq_req_out && irq_src_out > 5'h02 |-> irq_vector_out + {10'h000, irq_src_out, 1'b0} == 16'hfffe; endproperty
	a_vec: assert property (p_vec) else $error("latch vector wrong");
	property p_swv; irq_req_out && irq_src_out < 5'h03 |-> irq_vector_out == 16'hfffc && irq_nmi_out; endproperty
	a_swv: assert property (p_swv) else $error("latchless vector wrong");
	property p_clr; cpu_ack_in && irq_req_out && irq_src_out > 5'h02 && !src_req_in[irq_src_out] |=> !(irq_req_out && irq_src_out == $past(irq_src_out)); endproperty
	a_clr: assert property (p_clr) else $error("accepted latch not cleared");
	property p_pl0; sfr_rd_in && sfr_addr_in == 12'hfe0 |=> sfr_rdata_out[2:0] == 3'h0; endproperty
	a_pl0: assert property (p_pl0) else $error("unused low bits set");
	property p_pl3; sfr_rd_in && sfr_addr_in == 12'hfe3 |=> sfr_rdata_out[7:4] == 4'h0; endproperty
	a_pl3: assert property (p_pl3) else $error("unused high bits set");
endmodule : ile_unit_props
bind ile_unit ile_unit_props i_props (.*);

/* File: verification/ile_cpu_model.sv */
`timescale 1ns/1ps
module ile_cpu_model
(
	input  wire logic sys_clk_in,  // Clock
	input  wire logic rst_in,      // Reset
	input  wire logic en_in,       // Accept requests
	input  wire logic req_in,      // Request presented
	input  wire logic stk_in,      // Stacked master enable
	output logic      ack_out,     // Accept pulse
	output logic      return_from_irq_instr_out,    // Return pulse
	output logic      return_from_irq_instr_imf_out // Value restored
);
	int cnt = 0;
	// Accept, run a short handler, then return with the stacked enable
	always @(negedge sys_clk_in)
	begin
		ack_out <= 1'b0;
		return_from_irq_instr_out <= 1'b0;
		if (rst_in)
			cnt <= 0;
		else if (cnt != 0)
		begin
			cnt <= cnt - 1;
			return_from_irq_instr_out <= (cnt == 1);
		end
		else if (en_in && req_in)
		begin
			ack_out <= 1'b1;
			cnt <= 4;
		end
	end
	// Known level even before the first reset edge
	assign return_from_irq_instr_imf_out = (stk_in === 1'b1);
endmodule : ile_cpu_model

/* File: verification/ile_unit_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fail_count++; \
	$display("Error %s exp %h got %h", n, e, s); end end
module ile_unit_tb;
	logic                 sys_clk_in, rst_in, sfr_wr_in, sfr_rd_in, ei_in, di_in, cpu_en;
	logic                 return_from_irq_instr_in, return_from_irq_instr_imf_in, cpu_ack_in, irq_req_out, irq_nmi_out;
	logic                 imf_stack_out, imf_out, software_irq_in, undef_irq_in;
	logic [11:0]          sfr_addr_in;
	logic [7:0]           sfr_wdata_in, sfr_rdata_out;
	logic [27:3]          src_req_in;
	logic [4:0]           irq_src_out;
	logic [15:0]          irq_vector_out;
	ile_pkg::ile_levels_t level_in;
	int                   fail_count, cmp_count;
	logic [11:0]          ra [8] = '{12'hfe0, 12'hfe1, 12'hfe2, 12'hfe3, 12'h03a, 12'h03b,
		12'h03c, 12'h03d};
	ile_unit i_dut (.*);
	ile_cpu_model i_cpu (.sys_clk_in, .rst_in, .en_in(cpu_en), .req_in(irq_req_out),
		.stk_in(imf_stack_out), .ack_out(cpu_ack_in), .return_from_irq_instr_out(return_from_irq_instr_in), .return_from_irq_instr_imf_out(return_from_irq_instr_imf_in));
	// One register access; a read compares against d
	task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [27:3] r);
		@(negedge sys_clk_in);
		{sfr_wr_in, sfr_rd_in, sfr_addr_in, sfr_wdata_in, src_req_in} = {w, !w, a, d, r};
		@(negedge sys_clk_in);
		{sfr_wr_in, sfr_rd_in, src_req_in} = '0;
		if (!w) `CHK("rdata", d, sfr_rdata_out)
	endtask : acc
	// One-cycle instruction pulse
	task automatic pulse(ref logic s);
		@(negedge sys_clk_in);
		s = 1'b1;
		@(negedge sys_clk_in);
		s = 1'b0;
	endtask : pulse
	task automatic print_verdict();
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : print_verdict
	// Free-running 125 MHz clock
	initial
	begin
		sys_clk_in = 1'b0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	// Hang guard, well beyond the few hundred cycles the tests need
	initial
	begin
		#20000;
		fail_count++;
		print_verdict();
	end
	// Main sequence
	initial
	begin
		{sfr_addr_in, sfr_wr_in, sfr_rd_in, sfr_wdata_in, src_req_in, ei_in, di_in, cpu_en} = '0;
		level_in = '0;
		{software_irq_in, undef_irq_in} = 2'h0;
		level_in[16] = 2'h3;
		{fail_count, cmp_count} = '0;
		rst_in = 1'b1;
		repeat (4) @(negedge sys_clk_in);
		rst_in = 1'b0;
		foreach (ra[i]) acc(0, ra[i], 8'h00, '0);
		acc(1, 12'h100, 8'hff, '1);
		acc(0, 12'hfe0, 8'hf8, '0);
		acc(0, 12'hfe1, 8'hff, '0);
		acc(0, 12'hfe2, 8'hff, '0);
		acc(0, 12'hfe3, 8'h0f, '0);
		acc(0, 12'h100, 8'h00, '0);
		`CHK("watchdog", 7'h63, {irq_req_out, irq_nmi_out, irq_src_out})
		acc(1, 12'hfe0, 8'hff, '0);
		acc(0, 12'hfe0, 8'hf8, '0);
		acc(1, 12'hfe0, 8'h00, '0);
		acc(0, 12'hfe0, 8'h08, '0);
		acc(1, 12'hfe1, 8'hfe, '0);
		acc(0, 12'hfe1, 8'hfe, '0);
		acc(1, 12'hfe2, 8'h00, '0);
		acc(1, 12'hfe2, 8'h00, 25'h0002000);
		acc(0, 12'hfe2, 8'h01, '0);
		cpu_en = 1'b1;
		repeat (10) @(negedge sys_clk_in);
		acc(0, 12'hfe0, 8'h00, '0);
		pulse(di_in);
		acc(1, 12'h03a, 8'hf0, '0);
		acc(1, 12'h03b, 8'hff, '0);
		acc(1, 12'h03c, 8'hff, '0);
		acc(0, 12'h03a, 8'hf0, '0);
		pulse(ei_in);
		for (int i = 0; i < 20 && irq_req_out !== 1'b1; i++) @(negedge sys_clk_in);
		`CHK("source", 5'h10, irq_src_out)
		`CHK("vector", 16'hffde, irq_vector_out)
		repeat (100) @(negedge sys_clk_in);
		acc(0, 12'hfe1, 8'h00, '0);
		acc(0, 12'hfe3, 8'h0f, '0);
		`CHK("enables", 2'h3, {imf_out, imf_stack_out})
		acc(1, 12'h03a, 8'h00, '0);
		acc(1, 12'h03d, 8'h0f, '0);
		repeat (20) @(negedge sys_clk_in);
		acc(0, 12'hfe3, 8'h0f, '0);
		acc(0, 12'h03d, 8'h0f, '0);
		cpu_en = 1'b0;
		rst_in = 1'b1;
		repeat (2) @(negedge sys_clk_in);
		rst_in = 1'b0;
		acc(0, 12'hfe3, 8'h00, '0);
		acc(0, 12'h03d, 8'h00, '0);
		{software_irq_in, undef_irq_in} = 2'h3;
		@(negedge sys_clk_in);
		`CHK("software", 7'h61, {irq_req_out, irq_nmi_out, irq_src_out})
		`CHK("swvector", 16'hfffc, irq_vector_out)
		software_irq_in = 1'b0;
		@(negedge sys_clk_in);
		`CHK("undefined", 7'h62, {irq_req_out, irq_nmi_out, irq_src_out})
		acc(1, 12'h100, 8'h00, 25'h0000001);
		`CHK("wdtfirst", 7'h63, {irq_req_out, irq_nmi_out, irq_src_out})
		undef_irq_in = 1'b0;
		acc(0, 12'hfe0, 8'h08, '0);
		print_verdict();
	end
endmodule : ile_unit_tb
